// >>> hdl/mtm_sync.sv
// Two-flop synchroniser with combinational rise and fall detection
`timescale 1ns/1ps
module mtm_sync #(
   parameter int STAGES = 2
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_async,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic [STAGES-1:0] sync_ff;
   logic              prev_ff;

   // Elaboration check: one flop alone does not settle a metastable input
   if (STAGES < 2) begin : g_bad_stages
      $error("mtm_sync needs at least two stages");
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync_ff <= '0;
         prev_ff <= 1'b0;
      end else begin
         sync_ff <= {sync_ff[STAGES-2:0], i_async};
         prev_ff <= sync_ff[STAGES-1];
      end
   end

   assign o_level = sync_ff[STAGES-1];
   assign o_rise  = sync_ff[STAGES-1] & ~prev_ff;
   assign o_fall  = ~sync_ff[STAGES-1] & prev_ff;
endmodule : mtm_sync

// >>> hdl/mtm_timer.sv
// Modulo timer core with APB register slave
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "mtm_defs.svh"
module mtm_timer (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_fixed_frequency_clock,
   input  wire logic        i_external_count_clock_pin,
   input  wire logic        i_stop_mode,
   input  wire logic        i_deep_stop_wake,
   input  wire logic        i_debug_active,
   output logic             o_irq
);
   // ******************************************************
   // Declarations
   // ******************************************************
   logic       flag_ff;
   logic       ie_ff;
   logic       halt_ff;
   logic [1:0] clksel_ff;
   logic [3:0] div_sel_ff;
   logic [7:0] cnt_ff;
   logic [7:0] mod_ff;
   logic [7:0] pre_ff;
   logic       armed_ff;
   logic       pin_level;
   logic       pin_rise;
   logic       pin_fall;
   logic       fix_rise;
   logic       src_tick;
   logic       cnt_tick;
   logic       run;
   logic       soft_rst;
   logic       wr_acc;
   logic       rd_acc;
   logic       wr_lane0;
   logic       addr_ok;
   logic [7:0] pre_div;
   logic [7:0] nxt_pre;
   logic [7:0] rd_byte;
   logic       wr_sc;
   logic       wr_mod;
   logic       rd_sc;
   logic       clr_by_sw;
   logic       ovf_evt;
   logic [2:0] pwr_view;

   // ******************************************************
   // Bus decode
   // ******************************************************
   assign wr_acc   = i_psel & i_penable & i_pwrite & o_pready;
   assign rd_acc   = i_psel & i_penable & ~i_pwrite & o_pready;
   assign wr_lane0 = wr_acc & i_pstrb[0];
   assign addr_ok  = (i_paddr == `MTM_OFS_SC) | (i_paddr == `MTM_OFS_CLK)
                   | (i_paddr == `MTM_OFS_CNT) | (i_paddr == `MTM_OFS_MOD)
                   | (i_paddr == `MTM_OFS_PWR);
   assign wr_sc    = wr_lane0 & (i_paddr == `MTM_OFS_SC);
   assign wr_mod   = wr_lane0 & (i_paddr == `MTM_OFS_MOD);
   assign rd_sc    = rd_acc & (i_paddr == `MTM_OFS_SC);
   assign soft_rst = wr_sc & i_pwdata[`MTM_SC_RST_BIT];

   // Stop-mode and debug view, read at the power status offset
   assign pwr_view = i_stop_mode ? mtm_pkg::MTM_PWR_STOP
                   : (i_debug_active ? mtm_pkg::MTM_PWR_DBG : mtm_pkg::MTM_PWR_RUN);

   // ******************************************************
   // Clock source selection
   // ******************************************************
   // pin synchroniser
   mtm_sync #(
      .STAGES (`MTM_SYNC_STAGES)
   ) u_pin_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_async (i_external_count_clock_pin),
      .o_level (pin_level),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   // Fixed clock is another domain, so it is synchronised too
   mtm_sync #(
      .STAGES (`MTM_SYNC_STAGES)
   ) u_fix_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_async (i_fixed_frequency_clock),
      .o_level (),
      .o_rise  (fix_rise),
      .o_fall  ()
   );

   always_comb begin
      unique case (mtm_pkg::mtm_src_t'(clksel_ff))
         mtm_pkg::MTM_SRC_BUS:   src_tick = 1'b1;
         mtm_pkg::MTM_SRC_FIXED: src_tick = fix_rise;
         mtm_pkg::MTM_SRC_PIN_F: src_tick = pin_fall;
         mtm_pkg::MTM_SRC_PIN_R: src_tick = pin_rise;
      endcase
   end

   always_comb begin
      if (div_sel_ff > `MTM_DIV_MAX_CODE) begin
         pre_div = 8'hff;
      end else begin
         pre_div = 8'((9'h001 << div_sel_ff) - 9'h001);
      end
   end

   // counting gated by halt, stop and debug; state held
   assign run      = ~halt_ff & ~i_stop_mode & ~i_debug_active;
   assign cnt_tick = run & src_tick & (pre_ff >= pre_div);
   assign nxt_pre  = (pre_ff >= pre_div) ? 8'h00 : pre_ff + 8'h01;

   // ******************************************************
   // Prescaler and counter
   // ******************************************************
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         pre_ff <= 8'h00;
      end else if (soft_rst || wr_mod) begin
         pre_ff <= 8'h00;
      end else if (run && src_tick) begin
         pre_ff <= nxt_pre;
      end
   end

   // counter with modulo wrap and soft reset
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         cnt_ff <= `MTM_RST_CNT;
      end else if (soft_rst || wr_mod) begin
         cnt_ff <= `MTM_RST_CNT;
      end else if (cnt_tick) begin
         cnt_ff <= (mod_ff != 8'h00 && cnt_ff == mod_ff) ? 8'h00 : cnt_ff + 8'h01;
      end
   end

   // overflow when count at limit (free-running: 0xff) rolls
   assign ovf_evt = cnt_tick & (cnt_ff == ((mod_ff == 8'h00) ? 8'hff : mod_ff));

   // ******************************************************
   // Status and control
   // ******************************************************
   // Read of status with flag set arms the clear
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         armed_ff <= 1'b0;
      end else if (rd_sc) begin
         armed_ff <= flag_ff;
      end else if (wr_sc || !flag_ff) begin
         armed_ff <= 1'b0;
      end
   end

   assign clr_by_sw = (wr_sc & armed_ff & ~i_pwdata[`MTM_SC_FLAG_BIT]) | soft_rst | wr_mod;

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         flag_ff <= 1'b0;
      end else if (ovf_evt) begin
         flag_ff <= 1'b1;
      end else if (clr_by_sw) begin
         flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         ie_ff   <= 1'b0;
         halt_ff <= `MTM_RST_HALT;
      end else if (wr_sc) begin
         ie_ff   <= i_pwdata[`MTM_SC_IE_BIT];
         halt_ff <= i_pwdata[`MTM_SC_HALT_BIT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         clksel_ff  <= `MTM_RST_CLKSEL;
         div_sel_ff <= `MTM_RST_DIVSEL;
      end else if (wr_lane0 && i_paddr == `MTM_OFS_CLK) begin
         clksel_ff  <= i_pwdata[`MTM_CLK_SEL_MSB:`MTM_CLK_SEL_LSB];
         div_sel_ff <= i_pwdata[`MTM_CLK_DIV_MSB:`MTM_CLK_DIV_LSB];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         mod_ff <= `MTM_RST_MOD;
      end else if (wr_mod) begin
         mod_ff <= i_pwdata[7:0];
      end
   end

   // interrupt request, also the wait wake-up
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_deep_stop_wake) begin
         o_irq <= 1'b0;
      end else begin
         // Next flag value, so an overflow beside a clear keeps the request
         o_irq <= (ovf_evt | (flag_ff & ~clr_by_sw)) & ie_ff;
      end
   end

   // ******************************************************
   // APB read and answer
   // ******************************************************
   always_comb begin
      unique case (i_paddr)
         `MTM_OFS_SC:  rd_byte = {flag_ff, ie_ff, 1'b0, halt_ff, 4'h0};
         `MTM_OFS_CLK: rd_byte = {2'h0, clksel_ff, div_sel_ff};
         `MTM_OFS_CNT: rd_byte = cnt_ff;
         `MTM_OFS_MOD: rd_byte = mod_ff;
         `MTM_OFS_PWR: rd_byte = {4'h0, pin_level, pwr_view};
         default:      rd_byte = 8'h00;
      endcase
   end

   // No wait state: pready rises in the first access cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel && !i_penable) begin
         o_pready  <= 1'b1;
         o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         o_pslverr <= ~addr_ok;
      end else begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
   end
endmodule : mtm_timer

// >>> include/mtm_defs.svh
// Constants for the modulo timer: offsets, fields, resets, timing
`ifndef MTM_DEFS_SVH
`define MTM_DEFS_SVH

`define MTM_OFS_SC          12'h000
`define MTM_OFS_CLK         12'h004
`define MTM_OFS_CNT         12'h008
`define MTM_OFS_MOD         12'h00c
`define MTM_OFS_PWR         12'h010

`define MTM_SC_FLAG_BIT     7
`define MTM_SC_IE_BIT       6
`define MTM_SC_RST_BIT      5
`define MTM_SC_HALT_BIT     4
`define MTM_CLK_SEL_MSB     5
`define MTM_CLK_SEL_LSB     4
`define MTM_CLK_DIV_MSB     3
`define MTM_CLK_DIV_LSB     0

`define MTM_RST_HALT        1'h1
`define MTM_RST_CLKSEL      2'h0
`define MTM_RST_DIVSEL      4'h0
`define MTM_RST_MOD         8'h00
`define MTM_RST_CNT         8'h00

`define MTM_DIV_MAX_CODE    4'h8
`define MTM_SYNC_STAGES     2

`endif

// >>> include/mtm_pkg.sv
// Types shared by the modulo timer design
package mtm_pkg;
   typedef enum logic [1:0] {
      MTM_SRC_BUS   = 2'h0,
      MTM_SRC_FIXED = 2'h1,
      MTM_SRC_PIN_F = 2'h2,
      MTM_SRC_PIN_R = 2'h3
   } mtm_src_t;

   typedef enum logic [2:0] {
      MTM_PWR_RUN  = 3'h1,
      MTM_PWR_STOP = 3'h2,
      MTM_PWR_DBG  = 3'h4
   } mtm_pwr_t;
endpackage : mtm_pkg

// >>> verification/mtm_timer_chk.sv
// Port checker for the modulo timer
`timescale 1ns/1ps
module mtm_chk (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_stop_mode,
   input wire logic        i_deep_stop_wake,
   input wire logic        i_debug_active,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   logic acc;
   logic hold;
   assign acc  = i_psel && i_penable && o_pready && i_pwrite;
   assign hold = i_stop_mode || i_debug_active;
   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   ready_next_a : assert property (setup_s |=> o_pready)
      else $error("no answer after setup");
   ready_pulse_a : assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   ready_access_a : assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access");
   err_data_a : assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("bad error answer");
   upper_zero_a : assert property (o_pready |-> o_prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   // A wake from deep stop resets the flag and the request register itself
   irq_fall_a : assert property ($fell(o_irq) |-> $past(acc) || $past(acc, 2)
      || $past(i_deep_stop_wake))
      else $error("irq dropped without a write");
   // Flag can only rise through counting, which stop and debug forbid
   irq_hold_a : assert property ($rose(o_irq) |-> $past(acc, 2) || !$past(hold))
      else $error("irq rose while held");
   wake_clear_a : assert property (i_deep_stop_wake |-> ##[1:3] !o_irq)
      else $error("irq kept after wake");
endmodule : mtm_chk

bind mtm_timer mtm_chk u_chk (.*);

// >>> verification/tb_top.sv
// Self-checking bench for the modulo timer
`timescale 1ns/1ps
module tb_top;
   logic        i_clk = 1'h0, i_nrst = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
   logic        i_pwrite = 1'h0, i_stop_mode = 1'h0, i_deep_stop_wake = 1'h0;
   logic        i_debug_active = 1'h0, i_fixed_frequency_clock = 1'h0;
   logic        i_external_count_clock_pin = 1'h0, o_pready, o_pslverr, o_irq, er;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [3:0]  i_pstrb = 4'hf;
   logic [7:0]  c, d;
   int          err_count = 0, num_checks = 0, ph = 0;
   always #2 i_clk = ~i_clk;
   // slow pins: both toggle every 4 cycles, an edge pair per 8
   always @(posedge i_clk) begin
      ph <= ph + 1;
      i_fixed_frequency_clock <= ph[2];
      i_external_count_clock_pin <= ph[2];
   end
   mtm_timer u_dut (.*);
   task automatic results;
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: %h vs %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n = 0;
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= v;
      @(posedge i_clk) i_penable <= 1'h1;
      do @(posedge i_clk); while (o_pready !== 1'h1 && ++n < 20);
      rd = o_prdata;
      er = o_pslverr;
      chk(o_pready, 1'h1);
      if (o_pready !== 1'h1) results();
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      @(posedge i_clk);
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk
   task automatic t_regs;
      rdchk(12'h000, 32'h10);
      rdchk(12'h004, 32'h0);
      rdchk(12'h00c, 32'h0);
      rdchk(12'h014, 32'h0);
      chk(er, 1'h1);
      i_pstrb <= 4'he;
      apb(1'h1, 12'h00c, 32'h55);
      i_pstrb <= 4'hf;
      apb(1'h1, 12'h008, 32'h77);
      rdchk(12'h00c, 32'h0);
      rdchk(12'h008, 32'h0);
      apb(1'h1, 12'h004, 32'h3f);
      rdchk(12'h004, 32'h3f);
      apb(1'h1, 12'h004, 32'h0);
      apb(1'h1, 12'h000, 32'hff);
      rdchk(12'h000, 32'h50);
   endtask : t_regs
   task automatic t_wrap;
      apb(1'h1, 12'h00c, 32'h3);
      apb(1'h1, 12'h000, 32'h0);
      repeat (10) @(posedge i_clk);
      apb(1'h1, 12'h000, 32'h10);
      apb(1'h0, 12'h008, 32'h0);
      chk(rd < 32'h4, 1'h1);
      // A write without a prior flagged read must not clear
      rdchk(12'h000, 32'h90);
      apb(1'h1, 12'h000, 32'h10);
      rdchk(12'h000, 32'h10);
      apb(1'h1, 12'h000, 32'h30);
      rdchk(12'h008, 32'h0);
   endtask : t_wrap
   task automatic t_irq;
      int n = 0;
      apb(1'h1, 12'h000, 32'h40);
      while (o_irq !== 1'h1 && n++ < 50) @(posedge i_clk);
      chk(o_irq, 1'h1);
      if (o_irq !== 1'h1) results();
      apb(1'h1, 12'h000, 32'h50);
      rdchk(12'h000, 32'hd0);
      apb(1'h1, 12'h000, 32'h50);
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'h0);
      apb(1'h1, 12'h000, 32'h0);
      repeat (20) @(posedge i_clk);
      chk(o_irq, 1'h0);
   endtask : t_irq
   task automatic t_hold(input logic g);
      apb(1'h1, 12'h00c, 32'h0);
      apb(1'h1, 12'h000, 32'h0);
      i_stop_mode <= !g;
      i_debug_active <= g;
      repeat (4) @(posedge i_clk);
      apb(1'h0, 12'h008, 32'h0);
      c = rd[7:0];
      apb(1'h0, 12'h010, 32'h0);
      chk(rd[2:0], g ? 3'h4 : 3'h2);
      repeat (20) @(posedge i_clk);
      rdchk(12'h008, {24'h0, c});
      i_stop_mode <= 1'h0;
      i_debug_active <= 1'h0;
      repeat (8) @(posedge i_clk);
      apb(1'h0, 12'h008, 32'h0);
      d = rd[7:0] - c;
      chk(d > 8'h0 && d < 8'h20, 1'h1);
   endtask : t_hold
   task automatic t_rate(input logic [1:0] s, input logic [3:0] p, input int w);
      apb(1'h1, 12'h00c, 32'h0);
      apb(1'h1, 12'h004, {26'h0, s, p});
      apb(1'h1, 12'h000, 32'h20);
      apb(1'h0, 12'h008, 32'h0);
      c = rd[7:0];
      repeat (w) @(posedge i_clk);
      apb(1'h0, 12'h008, 32'h0);
      d = rd[7:0] - c;
      chk(d > 8'h30 && d < 8'h34, 1'h1);
   endtask : t_rate
   task automatic t_wake;
      apb(1'h1, 12'h004, 32'h1);
      apb(1'h1, 12'h00c, 32'h1);
      apb(1'h1, 12'h000, 32'h40);
      repeat (80) @(posedge i_clk);
      i_deep_stop_wake <= 1'h1;
      @(posedge i_clk);
      i_deep_stop_wake <= 1'h0;
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'h0);
      rdchk(12'h000, 32'h10);
      rdchk(12'h004, 32'h0);
      rdchk(12'h00c, 32'h0);
   endtask : t_wake
   initial begin
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'h1;
      @(posedge i_clk);
      t_regs();
      t_wrap();
      t_irq();
      t_hold(1'h0);
      t_hold(1'h1);
      // Windows are sized for fifty counts at every divider and source
      for (int p = 0; p < 10; p++) t_rate(2'h0, p[3:0], (50 << (p > 8 ? 8 : p)) - 3);
      for (int s = 1; s < 4; s++) t_rate(s[1:0], 4'h0, 397);
      t_wake();
      results();
   end
endmodule : tb_top
